// >>> design/aid_alu_incdec.v
// integer increment/decrement, top-bit detect and rounding datapath
//
// Functional notes
// - prefix 111110 then operation word, one state
// - decrement upper half, clear lower half
// - increment upper half, clear lower half
// - gated decrement runs only on matching flag
// - gated increment runs only on matching flag
// - unconditional forms update flag; gated forms keep
// - top-bit position to upper half, lower cleared
// - gated top-bit detect runs only on match
// - rounding adds 0x00008000, lower half cleared
`timescale 1ns/1ps
`default_nettype none
`include "aid_consts.vh"

module aid_alu_incdec #(
	parameter DW = 32
) (
	// clock and reset
	input  wire          clk,
	input  wire          rst_n,
	// instruction from decoder
	input  wire          insn_valid,
	input  wire [15:0]   insn_w0,
	input  wire [15:0]   insn_w1,
	// source operands read from the register file
	input  wire [DW-1:0] x_side_source,
	input  wire [DW-1:0] y_side_source,
	// register selects toward the register file
	output reg  [1:0]    src_sel_r,
	output reg           src_is_y_r,
	output reg  [3:0]    dst_sel_r,
	// destination write
	output reg           dst_we_r,
	output reg  [DW-1:0] destination_reg,
	// condition flag and completion
	output reg           dsp_condition_flag,
	output reg           done_r
);

	localparam HW = DW / 2;

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------

	// position of the top significant bit, counted as a shift amount:
	// leading bits equal to the sign minus one; zero and all-ones give
	// the full width less one, kept small so it fits the upper half
	function [HW-1:0] top_bit_pos;
		input [DW-1:0] v;
		integer i;
		reg     done;
		reg [HW-1:0] n;
		begin
			done = 1'b0;
			n    = {HW{1'b0}};
			for (i = DW - 2; i >= 0; i = i - 1) begin
				if (!done && v[i] == v[DW-1])
					n = n + 1'b1;
				else
					done = 1'b1;
			end
			top_bit_pos = n;
		end
	endfunction

	// flag gate: 2'b00 always, 2'b10 needs flag set, 2'b11 needs flag clear
	function gate_ok;
		input [1:0] g;
		input       f;
		begin
			case (g)
				2'b10:   gate_ok = f;
				2'b11:   gate_ok = ~f;
				default: gate_ok = 1'b1;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------------
	reg          hit;
	reg          use_y;
	reg  [1:0]   gate;
	reg  [1:0]   kind; // 0 dec, 1 inc, 2 msb, 3 rnd
	wire [7:0]   op = insn_w1[`AID_OP_HI:`AID_OP_LO];
	wire         pre = insn_w0[`AID_PREFIX_HI:`AID_PREFIX_LO] == `AID_PREFIX;
	// y forms carry zeros where x would sit, x forms zeros in the y slot
	wire         xfmt = insn_w1[`AID_Y_HI:`AID_Y_LO] == 2'h0;
	wire         yfmt = insn_w1[`AID_X_HI:`AID_X_LO] == 2'h0;

	always @* begin
		hit   = 1'b1;
		use_y = 1'b0;
		gate  = 2'b00;
		kind  = 2'd0;
		case (op)
			// decrement family
			`AID_OP_DEC_X:  kind = 2'd0;
			`AID_OP_DECT_X: begin
				kind = 2'd0;
				gate = 2'b10;
			end
			`AID_OP_DECF_X: begin
				kind = 2'd0;
				gate = 2'b11;
			end
			`AID_OP_DEC_Y:  begin
				kind  = 2'd0;
				use_y = 1'b1;
			end
			`AID_OP_DECT_Y: begin
				kind  = 2'd0;
				use_y = 1'b1;
				gate  = 2'b10;
			end
			`AID_OP_DECF_Y: begin
				kind  = 2'd0;
				use_y = 1'b1;
				gate  = 2'b11;
			end
			// increment family
			`AID_OP_INC_X:  kind = 2'd1;
			`AID_OP_INCT_X: begin
				kind = 2'd1;
				gate = 2'b10;
			end
			`AID_OP_INCF_X: begin
				kind = 2'd1;
				gate = 2'b11;
			end
			`AID_OP_INC_Y:  begin
				kind  = 2'd1;
				use_y = 1'b1;
			end
			`AID_OP_INCT_Y: begin
				kind  = 2'd1;
				use_y = 1'b1;
				gate  = 2'b10;
			end
			`AID_OP_INCF_Y: begin
				kind  = 2'd1;
				use_y = 1'b1;
				gate  = 2'b11;
			end
			// top-bit detect family
			`AID_OP_MSB_X:  kind = 2'd2;
			`AID_OP_MSBT_X: begin
				kind = 2'd2;
				gate = 2'b10;
			end
			`AID_OP_MSBF_X: begin
				kind = 2'd2;
				gate = 2'b11;
			end
			`AID_OP_MSB_Y:  begin
				kind  = 2'd2;
				use_y = 1'b1;
			end
			`AID_OP_MSBT_Y: begin
				kind  = 2'd2;
				use_y = 1'b1;
				gate  = 2'b10;
			end
			`AID_OP_MSBF_Y: begin
				kind  = 2'd2;
				use_y = 1'b1;
				gate  = 2'b11;
			end
			// rounding has no gated forms
			`AID_OP_RND_X:  kind = 2'd3;
			`AID_OP_RND_Y:  begin
				kind  = 2'd3;
				use_y = 1'b1;
			end
			default:        hit = 1'b0;
		endcase
		// the unused source slot must be zero or the word is not ours
		if (use_y ? !yfmt : !xfmt)
			hit = 1'b0;
	end

	// ----------------------------------------------------------------------
	// compute
	// ----------------------------------------------------------------------
	wire [DW-1:0] src = use_y ? y_side_source : x_side_source;
	reg  [DW-1:0] res;

	always @* begin
		case (kind)
			2'd0:    res = {src[DW-1:HW] - 1'b1, {HW{1'b0}}};
			2'd1:    res = {src[DW-1:HW] + 1'b1, {HW{1'b0}}};
			2'd2:    res = {top_bit_pos(src), {HW{1'b0}}};
			default: begin
				res = src + `AID_RND_CONST;
				res[HW-1:0] = {HW{1'b0}};
			end
		endcase
	end

	// condition flag from the result: set when the written value is zero;
	// a narrow stand-in since the flag mode select lives elsewhere
	wire res_zero = res == {DW{1'b0}};
	wire go       = insn_valid && pre && hit;
	wire runs     = go && gate_ok(gate, dsp_condition_flag);

	// ----------------------------------------------------------------------
	// single-state execution register
	// ----------------------------------------------------------------------
	// everything retires one edge after the request; a failed gate is a
	// plain no-operation with no write and no flag change
	always @(posedge clk) begin
		if (!rst_n) begin
			src_sel_r          <= 2'h0;
			src_is_y_r         <= 1'b0;
			dst_sel_r          <= 4'h0;
			dst_we_r           <= 1'b0;
			destination_reg    <= {DW{1'b0}};
			dsp_condition_flag <= `AID_FLAG_RST;
			done_r             <= 1'b0;
		end else begin
			done_r   <= go;
			dst_we_r <= runs;
			if (go) begin
				src_is_y_r <= use_y;
				src_sel_r  <= use_y ? insn_w1[`AID_Y_HI:`AID_Y_LO]
				                    : insn_w1[`AID_X_HI:`AID_X_LO];
				dst_sel_r  <= insn_w1[`AID_Z_HI:`AID_Z_LO];
			end
			if (runs)
				destination_reg <= res;
			if (go && gate == 2'b00)
				dsp_condition_flag <= res_zero;
		end
	end

endmodule // aid_alu_incdec
`default_nettype wire

// >>> design/aid_consts.vh
// constants for the integer inc/dec, top-bit detect and rounding datapath
`ifndef AID_CONSTS_VH
`define AID_CONSTS_VH

// --------------------------------------------------------------------------
// opcode fields
// --------------------------------------------------------------------------
`define AID_PREFIX       6'h3E
`define AID_PREFIX_HI    15
`define AID_PREFIX_LO    10
`define AID_OP_HI        15
`define AID_OP_LO        8
`define AID_X_HI         7
`define AID_X_LO         6
`define AID_Y_HI         5
`define AID_Y_LO         4
`define AID_Z_HI         3
`define AID_Z_LO         0

// --------------------------------------------------------------------------
// operation codes, upper byte of the second word
// --------------------------------------------------------------------------
`define AID_OP_DEC_X     8'h89
`define AID_OP_DECT_X    8'h8A
`define AID_OP_DECF_X    8'h8B
`define AID_OP_DEC_Y     8'hA9
`define AID_OP_DECT_Y    8'hAA
`define AID_OP_DECF_Y    8'hAB
`define AID_OP_INC_X     8'h99
`define AID_OP_INCT_X    8'h9A
`define AID_OP_INCF_X    8'h9B
`define AID_OP_INC_Y     8'hB9
`define AID_OP_INCT_Y    8'hBA
`define AID_OP_INCF_Y    8'hBB
`define AID_OP_MSB_X     8'h9D
`define AID_OP_MSBT_X    8'h9E
`define AID_OP_MSBF_X    8'h9F
`define AID_OP_MSB_Y     8'hBD
`define AID_OP_MSBT_Y    8'hBE
`define AID_OP_MSBF_Y    8'hBF
`define AID_OP_RND_X     8'h98
`define AID_OP_RND_Y     8'hB8

// --------------------------------------------------------------------------
// values
// --------------------------------------------------------------------------
`define AID_RND_CONST    32'h00008000
`define AID_FLAG_RST     1'h0
`define AID_EXEC_STATES  1

`endif

// >>> test/aid_alu_incdec_sva.sv
// checker for the inc/dec, top-bit detect and rounding datapath
`timescale 1ns/1ps
`default_nettype none
module aid_alu_incdec_sva (
	// clock, reset and request
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        insn_valid,
	input wire logic [15:0] insn_w0,
	input wire logic [15:0] insn_w1,
	input wire logic [31:0] x_side_source,
	// results
	input wire logic        dst_we_r,
	input wire logic [31:0] destination_reg,
	input wire logic        dsp_condition_flag,
	input wire logic        done_r
);
	// prefix match, and x-side ops whose unused y field is clear
	wire       pfx = insn_valid && insn_w0[15:10] == 6'h3E;
	wire       xop = pfx && insn_w1[5:4] == 2'h0;
	wire [7:0] op  = insn_w1[15:8];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_idle_no_done: assert property (!pfx |=> !done_r) else $error("retire without request");
	a_write_retires: assert property (dst_we_r |-> done_r) else $error("write without retire");
	a_lower_clear: assert property (dst_we_r |-> destination_reg[15:0] == 16'h0)
		else $error("lower half not cleared");
	a_inc_upper: assert property (xop && op == 8'h99 |=> dst_we_r &&
		destination_reg[31:16] == $past(x_side_source[31:16]) + 16'h1) else $error("bad increment");
	a_round_sum: assert property (xop && op == 8'h98 |=>
		destination_reg == (($past(x_side_source) + 32'h8000) & 32'hFFFF0000)) else $error("bad round");
	a_gated_flag: assert property (pfx && insn_w1[9] |=> $stable(dsp_condition_flag))
		else $error("gated op changed flag");
	a_gated_skip: assert property (pfx && insn_w1[9] && insn_w1[8] == dsp_condition_flag
		|=> !dst_we_r) else $error("gated op ran on wrong flag");
	a_uncond_flag: assert property (xop && op inside {8'h89, 8'h99, 8'h98, 8'h9D}
		|=> dsp_condition_flag == (destination_reg == 32'h0)) else $error("flag not updated");
endmodule // aid_alu_incdec_sva
bind aid_alu_incdec aid_alu_incdec_sva aid_alu_incdec_sva_inst (.clk, .rst_n, .insn_valid, .insn_w0,
	.insn_w1, .x_side_source, .dst_we_r, .destination_reg, .dsp_condition_flag, .done_r);
`default_nettype wire

// >>> test/aid_alu_incdec_test.sv
// self-checking bench for the inc/dec, top-bit detect and rounding datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module aid_alu_incdec_test;
	logic        clk = 0, rst_n = 0, insn_valid = 0;
	logic [15:0] insn_w0 = 16'hF800, insn_w1 = 16'h0;
	logic [31:0] x_src = 32'h0, y_src = 32'h0;
	wire  [1:0]  src_sel;
	wire  [3:0]  dst_sel;
	wire         src_is_y, we, done, flag;
	wire  [31:0] dst;
	int          fails = 0, checks_done = 0;
	// op word, source, result, write, flag; the flag carries row to row
	logic [87:0] rows [25] = '{
		88'h9941_00050000_00060000_1_0, 88'h9A41_00000000_00060000_0_0,
		88'hBA12_00000000_00060000_0_0, 88'h8A41_00000000_00060000_0_0,
		88'h9E41_00000000_00060000_0_0, 88'h8B41_00050000_00040000_1_0,
		88'hBF12_00000001_001E0000_1_0, 88'h9B41_00001234_00010000_1_0,
		88'hBB12_FFFF0000_00000000_1_0, 88'hAB12_00000000_FFFF0000_1_0,
		88'h9F41_40000000_00000000_1_0, 88'hB912_00020000_00030000_1_0,
		88'hBD12_FFFFFFFF_001F0000_1_0, 88'h9D41_40000000_00000000_1_1,
		88'h8B41_00000000_00000000_0_1, 88'h9F41_00000000_00000000_0_1,
		88'hAA12_00000000_FFFF0000_1_1, 88'h9A41_FFFF5555_00000000_1_1,
		88'hBE12_FFFF0000_000F0000_1_1, 88'h8A41_00000000_FFFF0000_1_1,
		88'h9E41_00050000_000C0000_1_1, 88'hA912_00010000_00000000_1_1,
		88'hB812_FFFF8000_00000000_1_1, 88'h9841_12347FFF_12340000_1_0,
		88'h8941_00020000_00010000_1_0};
	aid_alu_incdec aid_alu_incdec_inst (.clk(clk), .rst_n(rst_n), .insn_valid(insn_valid),
		.insn_w0(insn_w0), .insn_w1(insn_w1), .x_side_source(x_src), .y_side_source(y_src),
		.src_sel_r(src_sel), .src_is_y_r(src_is_y), .dst_sel_r(dst_sel), .dst_we_r(we),
		.destination_reg(dst), .dsp_condition_flag(flag), .done_r(done));
	aid_regfile_model aid_regfile_model_inst (.clk(clk), .dst_we_r(we), .dst_sel_r(dst_sel),
		.destination_reg(dst));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial forever #25 clk = ~clk;
	// watchdog: a hang counts as a mismatch
	initial begin
		#100us;
		fails++;
		tally_and_finish;
	end
	// rows go back to back, one per cycle, sampled on the next falling edge
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1;
		for (int i = 0; i < 25; i++) begin
			insn_valid = 1;
			insn_w1 = rows[i][87:72];
			// op bit 5 marks a y-side form; the other side gets a decoy value
			x_src = rows[i][85] ? ~rows[i][71:40] : rows[i][71:40];
			y_src = rows[i][85] ? rows[i][71:40] : ~rows[i][71:40];
			@(negedge clk);
			`CHK(done, 1'b1)
			`CHK(we, rows[i][4])
			`CHK(dst, rows[i][39:8])
			`CHK(flag, rows[i][0])
			`CHK({src_is_y, src_sel, dst_sel}, {rows[i][85], 2'h1, rows[i][75:72]})
		end
		$display("row table done");
		// an op outside the set, a used y field on an x op, a wrong prefix: all ignored
		insn_w1 = 16'h8841;
		@(negedge clk);
		`CHK(done, 1'b0)
		insn_w1 = 16'h9951;
		@(negedge clk);
		`CHK(done, 1'b0)
		insn_w0 = 16'hF400;
		insn_w1 = 16'h9941;
		@(negedge clk);
		`CHK({done, dst}, {1'b0, 32'h00010000})
		`CHK(aid_regfile_model_inst.regs[1], 32'h00010000)
		insn_valid = 0;
		$display("refusal test done");
		rst_n = 0;
		@(negedge clk);
		`CHK({done, we, flag, dst}, 35'h0)
		$display("reset test done");
		// first request right on the release edge, then a held word with valid low
		rst_n = 1;
		insn_valid = 1;
		insn_w0 = 16'hF800;
		insn_w1 = 16'h9D41;
		x_src = 32'h40000000;
		@(negedge clk);
		`CHK({done, we, flag, dst}, {3'b111, 32'h0})
		insn_valid = 0;
		@(negedge clk);
		`CHK({done, we}, 2'b00)
		$display("restart test done");
		tally_and_finish;
	end
endmodule // aid_alu_incdec_test
`default_nettype wire

// >>> test/aid_regfile_model.sv
// register file model that takes the datapath's destination writes
`timescale 1ns/1ps
`default_nettype none
module aid_regfile_model (
	// clock and write side
	input wire logic        clk,
	input wire logic        dst_we_r,
	input wire logic [3:0]  dst_sel_r,
	input wire logic [31:0] destination_reg
);
	logic [31:0] regs [16];
	// only the write pulse lands; gated no-ops must leave the file alone
	always @(posedge clk)
		if (dst_we_r) regs[dst_sel_r] <= destination_reg;
endmodule // aid_regfile_model
`default_nettype wire
